//--- logic/otpcm_consts.svh
// Constants for the one-time-programmable code memory program and verify block
// Behaviour
// - Five low strobe pulses commit one byte
// - Any security bit blocks code and table writes
// - Verify returns code byte unless bits 2/3 set
// - Verify output is code XNOR encryption entry
// - Encryption table never readable
// - Signature read at 030H/031H with all four port-2/port-3 selects low
// - Two read-only identification bytes held
// - Bit 1 blocks table reads, latches access pin
// - Bits 2 and 3 also disable verify
// - All three bits forbid external execution
// - Encryption array set to all ones by blank init, not by reset
`ifndef OTPCM_CONSTS_SVH
`define OTPCM_CONSTS_SVH

`define OTPCM_CODE_AW        12
`define OTPCM_CODE_DEPTH     4096
`define OTPCM_ENC_AW         6
`define OTPCM_ENC_DEPTH      64
`define OTPCM_BLANK_BYTE     8'h_FF
`define OTPCM_PULSE_COUNT    3'h_5
`define OTPCM_SIG_ADDR_MAKER 12'h_030
`define OTPCM_SIG_ADDR_PART  12'h_031
// Identification bytes; both values are arbitrary
`define OTPCM_ID_MAKER       8'h_A5
`define OTPCM_ID_PART        8'h_3C
`define OTPCM_OSC_MIN_MHZ    4
`define OTPCM_OSC_MAX_MHZ    6
// Select pin codes {port2 bit7, port2 bit6, port3 bit7, port3 bit6}
`define OTPCM_SEL_SIGNATURE  4'h_0
`define OTPCM_SEL_PGM_CODE   4'h_B
`define OTPCM_SEL_VERIFY     4'h_3
`define OTPCM_SEL_PGM_ENC    4'h_A
`define OTPCM_SEL_PGM_SEC1   4'h_F
`define OTPCM_SEL_PGM_SEC2   4'h_C
`define OTPCM_SEL_PGM_SEC3   4'h_6

`endif

//--- logic/otpcm_pkg.sv
// Types for the code memory program and verify block
`default_nettype none
package otpcm_pkg;
    typedef enum logic [2:0] {
        OTPCM_IDLE,
        OTPCM_SIGNATURE,
        OTPCM_PGM_CODE,
        OTPCM_VERIFY,
        OTPCM_PGM_ENC,
        OTPCM_PGM_SEC
    } otpcm_mode_t;
endpackage : otpcm_pkg
`default_nettype wire

//--- logic/otpcm_strobe_if.sv
// Strobe counting link between the core and the pulse counter
`timescale 1ns/100ps
`default_nettype none
interface otpcm_strobe_if;
    logic       strobe;
    logic       arm;
    logic       commit;
    logic [2:0] count;
    modport core    (output strobe, output arm, input commit, input count);
    modport counter (input strobe, input arm, output commit, output count);
endinterface : otpcm_strobe_if
`default_nettype wire

//--- logic/otpcm_pulse_counter.sv
// Counts completed low pulses of the program strobe and flags a commit
`timescale 1ns/100ps
`default_nettype none
`include "otpcm_consts.svh"
module otpcm_pulse_counter (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    otpcm_strobe_if.counter  lnk
);
    logic       strobe_prev;
    logic [2:0] count;
    logic       commit;
    wire        pulse_end = lnk.strobe & ~strobe_prev;       // Rising edge ends a low pulse
    wire        last      = (count == `OTPCM_PULSE_COUNT - 3'h_1);

    // Count ended low pulses while armed, commit on the fifth
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            strobe_prev <= 1'b1;
            count       <= 3'h_0;
            commit      <= 1'b0;
        end else begin
            strobe_prev <= lnk.strobe;
            commit      <= lnk.arm & pulse_end & last;
            if (!lnk.arm)
                count <= 3'h_0;
            else if (pulse_end)
                count <= last ? 3'h_0 : count + 3'h_1;
        end
    end

    assign lnk.commit = commit;
    assign lnk.count  = count;
endmodule : otpcm_pulse_counter
`default_nettype wire

//--- logic/otpcm_core.sv
// Program, verify, signature and security logic of the on-chip code memory
`timescale 1ns/100ps
`default_nettype none
`include "otpcm_consts.svh"
module otpcm_core (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_blank_init,
    input  wire logic                    i_reset_pin,
    input  wire logic                    i_program_store_enable_n,
    input  wire logic                    i_program_pulse_strobe,
    input  wire logic                    i_external_access_prog_supply,
    input  wire logic                    i_external_access_select,
    input  wire logic                    i_port2_bit7_select,
    input  wire logic                    i_port2_bit6_select,
    input  wire logic                    i_port3_bit7_select,
    input  wire logic                    i_port3_bit6_select,
    input  wire logic [7:0]              i_port0,
    input  wire logic [7:0]              i_port1,
    input  wire logic [3:0]              i_port2,
    output logic [7:0]                   o_port0,
    output logic                         o_port0_oe,
    output otpcm_pkg::otpcm_mode_t       o_mode,
    output logic [2:0]                   o_security_bits,
    output logic                         o_program_disable,
    output logic                         o_verify_disable,
    output logic                         o_code_table_read_instruction_block,
    output logic                         o_ext_exec_block,
    output logic                         o_external_access_latched,
    output logic                         o_write_done,
    output logic                         o_write_refused
);
    import otpcm_pkg::*;

    // Non-volatile arrays: only the blank-init input sets them, never reset
    logic [7:0] code_mem [`OTPCM_CODE_DEPTH];
    logic [7:0] enc_mem  [`OTPCM_ENC_DEPTH];
    logic [2:0] sec_bits;
    logic [7:0] port0_q;
    logic       port0_oe_q;
    logic       access_latched;
    logic       write_done;
    logic       write_refused;
    logic       rst_pin_prev;

    otpcm_strobe_if strobe_lnk ();

    // Decodes the pin levels into a mode; used for the live mode and arming
    function automatic otpcm_mode_t decode_mode(input logic rst_pin, input logic store_en_n,
                                                input logic supply, input logic [3:0] sel);
        otpcm_mode_t m;
        m = OTPCM_IDLE;
        if (rst_pin && !store_en_n) begin
            case (sel)
                `OTPCM_SEL_SIGNATURE: m = OTPCM_SIGNATURE;
                `OTPCM_SEL_VERIFY:    m = OTPCM_VERIFY;
                `OTPCM_SEL_PGM_CODE:  m = supply ? OTPCM_PGM_CODE : OTPCM_IDLE;
                `OTPCM_SEL_PGM_ENC:   m = supply ? OTPCM_PGM_ENC : OTPCM_IDLE;
                `OTPCM_SEL_PGM_SEC1,
                `OTPCM_SEL_PGM_SEC2,
                `OTPCM_SEL_PGM_SEC3:  m = supply ? OTPCM_PGM_SEC : OTPCM_IDLE;
                default:              m = OTPCM_IDLE;
            endcase
        end
        return m;
    endfunction : decode_mode

    // Maps a security-bit select code to the bit it programs
    function automatic logic [2:0] sec_select(input logic [3:0] sel);
        logic [2:0] s;
        s = 3'h_0;
        case (sel)
            `OTPCM_SEL_PGM_SEC1: s = 3'h_1;
            `OTPCM_SEL_PGM_SEC2: s = 3'h_2;
            `OTPCM_SEL_PGM_SEC3: s = 3'h_4;
            default:             s = 3'h_0;
        endcase
        return s;
    endfunction : sec_select

    // Pin decoding and address assembly
    wire [3:0]               sel_code  = {i_port2_bit7_select, i_port2_bit6_select,
                                          i_port3_bit7_select, i_port3_bit6_select};
    wire otpcm_mode_t        mode      = decode_mode(i_reset_pin, i_program_store_enable_n,
                                                     i_external_access_prog_supply, sel_code);
    wire [`OTPCM_CODE_AW-1:0] addr     = {i_port2, i_port1};
    wire [`OTPCM_ENC_AW-1:0]  enc_idx  = addr[`OTPCM_ENC_AW-1:0];
    wire                     sec_any   = |sec_bits;
    wire                     write_mode = (mode == OTPCM_PGM_CODE) || (mode == OTPCM_PGM_ENC)
                                          || (mode == OTPCM_PGM_SEC);
    wire                     commit    = strobe_lnk.commit;

    // Write gating: any set security bit locks code and table, not other bits
    wire lock_arrays = sec_any;
    wire wr_code     = commit && (mode == OTPCM_PGM_CODE) && !lock_arrays;
    wire wr_enc      = commit && (mode == OTPCM_PGM_ENC) && !lock_arrays;
    wire wr_sec      = commit && (mode == OTPCM_PGM_SEC);
    wire wr_blocked  = commit && lock_arrays
                       && ((mode == OTPCM_PGM_CODE) || (mode == OTPCM_PGM_ENC));

    // Read path: verify ciphered by XNOR, signature from fixed bytes only
    wire verify_ok   = !sec_bits[1] && !sec_bits[2];
    wire [7:0] cipher = ~(code_mem[addr] ^ enc_mem[enc_idx]);
    wire sig_hit     = (addr == `OTPCM_SIG_ADDR_MAKER) || (addr == `OTPCM_SIG_ADDR_PART);
    wire [7:0] sig_byte = (addr == `OTPCM_SIG_ADDR_MAKER) ? `OTPCM_ID_MAKER
                                                          : `OTPCM_ID_PART;
    wire drive_verify = (mode == OTPCM_VERIFY) && verify_ok;
    wire drive_sig    = (mode == OTPCM_SIGNATURE) && sig_hit;
    wire [7:0] next_port0 = drive_verify ? cipher : (drive_sig ? sig_byte : 8'h_00);

    // Strobe counter armed only while a write mode is held
    assign strobe_lnk.strobe = i_program_pulse_strobe;
    assign strobe_lnk.arm    = write_mode;

    otpcm_pulse_counter u_pulse_counter (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .lnk       (strobe_lnk.counter)
    );

    // Code array: blank init fills ones, a commit stores one byte
    always_ff @(posedge i_ref_clk) begin
        for (int i = 0; i < `OTPCM_CODE_DEPTH; i++) begin
            if (i_blank_init)
                code_mem[i] <= `OTPCM_BLANK_BYTE;
            else if (wr_code && (addr == i[`OTPCM_CODE_AW-1:0]))
                code_mem[i] <= i_port0;
        end
    end

    // Encryption array: starts all ones, written only through the pulse train
    genvar g;
    generate
        for (g = 0; g < `OTPCM_ENC_DEPTH; g++) begin : g_enc
            always_ff @(posedge i_ref_clk) begin
                if (i_blank_init)
                    enc_mem[g] <= `OTPCM_BLANK_BYTE;
                else if (wr_enc && (enc_idx == g[`OTPCM_ENC_AW-1:0]))
                    enc_mem[g] <= i_port0;
            end
        end
    endgenerate

    // Security bits only ever set outside blank init, which clears them; system reset leaves them alone
    always_ff @(posedge i_ref_clk) begin
        if (i_blank_init)
            sec_bits <= 3'h_0;
        else if (wr_sec)
            sec_bits <= sec_bits | sec_select(sel_code);
    end

    // Port 0 drive and write result pulses
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            port0_q       <= 8'h_00;
            port0_oe_q    <= 1'b0;
            write_done    <= 1'b0;
            write_refused <= 1'b0;
        end else begin
            port0_q       <= next_port0;
            port0_oe_q    <= drive_verify | drive_sig;
            write_done    <= wr_code | wr_enc | wr_sec;
            write_refused <= wr_blocked;
        end
    end

    // Access-select latch: caught on release of the reset pin once bit 1 set
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rst_pin_prev <= 1'b1;
            access_latched <= 1'b0;
        end else begin
            rst_pin_prev <= i_reset_pin;
            if (!sec_bits[0] || (rst_pin_prev && !i_reset_pin))
                access_latched <= i_external_access_select;
        end
    end

    // Outputs of the security policy
    assign o_port0                             = port0_q;
    assign o_port0_oe                          = port0_oe_q;
    assign o_mode                              = mode;
    assign o_security_bits                     = sec_bits;
    assign o_program_disable                   = lock_arrays;
    assign o_verify_disable                    = !verify_ok;
    assign o_code_table_read_instruction_block = sec_any;
    assign o_ext_exec_block                    = &sec_bits;
    assign o_external_access_latched           = access_latched;
    assign o_write_done                        = write_done;
    assign o_write_refused                     = write_refused;
endmodule : otpcm_core
`default_nettype wire

//--- dv/otpcm_properties.sv
// Concurrent checks on the ports of the code memory program and verify block
`timescale 1ns/100ps
`default_nettype none
`include "otpcm_consts.svh"
module otpcm_checker (
    input wire logic                   i_ref_clk,
    input wire logic                   i_sys_rst,
    input wire logic                   i_blank_init,
    input wire logic                   i_program_pulse_strobe,
    input wire logic [7:0]             i_port1,
    input wire logic [3:0]             i_port2,
    input wire logic [7:0]             o_port0,
    input wire logic                   o_port0_oe,
    input wire otpcm_pkg::otpcm_mode_t o_mode,
    input wire logic [2:0]             o_security_bits,
    input wire logic                   o_program_disable,
    input wire logic                   o_verify_disable,
    input wire logic                   o_ext_exec_block,
    input wire logic                   o_write_done,
    input wire logic                   o_write_refused
);
    import otpcm_pkg::*;
    // One clock domain, reset masks every check
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // Port 0 drives only after a read mode, never table data
    a_oe_read_only: assert property (o_port0_oe |-> $past(o_mode) inside {OTPCM_VERIFY, OTPCM_SIGNATURE})
        else $error("port 0 driven outside a read mode");
    a_verify_locked: assert property (o_mode == OTPCM_VERIFY && o_verify_disable |=> !o_port0_oe)
        else $error("verify answered while locked");
    a_sig_maker: assert property (o_mode == OTPCM_SIGNATURE
        && {i_port2, i_port1} == `OTPCM_SIG_ADDR_MAKER
        |=> o_port0_oe && o_port0 == `OTPCM_ID_MAKER) else $error("maker byte wrong");
    a_refuse_locked: assert property (o_write_refused |-> o_program_disable)
        else $error("write refused while unlocked");
    // Commit only two cycles after the strobe returned high
    a_commit_after: assert property (o_write_done || o_write_refused
        |-> $past(i_program_pulse_strobe, 2) && !$past(i_program_pulse_strobe, 3)) else $error("early commit");
    a_sec_sticky: assert property (!$past(i_blank_init)
        |-> ($past(o_security_bits) & ~o_security_bits) == 3'h_0) else $error("security bit cleared");
    a_lock_decode: assert property (o_program_disable == |o_security_bits)
        else $error("program lock wrong");
    a_vexec_decode: assert property (o_verify_disable == |o_security_bits[2:1]
        && o_ext_exec_block == &o_security_bits) else $error("verify or exec lock wrong");
    // Main scenarios reached
    c_done: cover property (o_write_done);
    c_refused: cover property (o_write_refused);
    c_verify: cover property (o_mode == OTPCM_VERIFY ##1 o_port0_oe);
endmodule : otpcm_checker
`default_nettype wire

//--- dv/otpcm_prog_model.sv
// Programming system model: mode pins, address, data and program strobe
`timescale 1ns/100ps
`default_nettype none
module otpcm_prog_model (
    input  wire logic   i_ref_clk,
    output logic [3:0]  o_sel    = 4'h_5,
    output logic        o_strobe = 1'b1,
    output logic        o_supply = 1'b0,
    output logic [11:0] o_addr   = 12'h_000,
    output logic [7:0]  o_data   = 8'h_00
);
    // Levels held from before the first pulse until after the commit
    task automatic wr(input logic [3:0] s, input logic [11:0] a, input logic [7:0] d, input int n);
        @(negedge i_ref_clk);
        o_sel = s;
        o_supply = 1'b1;
        o_addr = a;
        o_data = d;
        repeat (n) begin
            @(negedge i_ref_clk);
            o_strobe = 1'b0;
            @(negedge i_ref_clk);
            o_strobe = 1'b1;
        end
        repeat (4) @(negedge i_ref_clk);
        o_sel = 4'h_5;
        o_supply = 1'b0;
        o_data = ~d; // Released data shows the inverse
    endtask : wr
    // Read setup; data valid after the next rising edge
    task automatic rd(input logic [3:0] s, input logic [11:0] a);
        @(negedge i_ref_clk);
        o_sel = s;
        o_supply = 1'b0;
        o_addr = a;
        @(negedge i_ref_clk);
    endtask : rd
endmodule : otpcm_prog_model
`default_nettype wire

//--- dv/otpcm_core_tb.sv
// Self-checking bench for the code memory program and verify block
`timescale 1ns/100ps
`default_nettype none
`include "otpcm_consts.svh"
module otpcm_core_tb;
    import otpcm_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_blank_init = 1'b1;
    logic        i_external_access_select = 1'b0;
    logic        rst_pin = 1'b1;
    logic        store_en_n = 1'b0;
    logic        acc_m = 1'b0;
    logic        strobe, supply, o_port0_oe, o_program_disable, o_verify_disable, o_write_done, o_write_refused;
    logic        o_ext_exec_block, o_code_table_read_instruction_block, o_external_access_latched;
    logic [3:0]  sel;
    logic [11:0] addr;
    logic [7:0]  wdata, o_port0;
    logic [2:0]  o_security_bits, sec_m;
    otpcm_mode_t o_mode;
    logic [7:0]  mem [4096];
    logic [7:0]  enc [64];
    logic [31:0] seed = 32'h_0000_D7DE;
    int          err_count, checks, n_done, n_ref, cyc;

    otpcm_core u_dut (.*, .i_reset_pin(rst_pin), .i_program_store_enable_n(store_en_n),
        .i_program_pulse_strobe(strobe), .i_external_access_prog_supply(supply),
        .i_port2_bit7_select(sel[3]), .i_port2_bit6_select(sel[2]), .i_port3_bit7_select(sel[1]),
        .i_port3_bit6_select(sel[0]), .i_port0(wdata), .i_port1(addr[7:0]), .i_port2(addr[11:8]));
    otpcm_prog_model u_prog (.i_ref_clk, .o_sel(sel), .o_strobe(strobe), .o_supply(supply), .o_addr(addr),
        .o_data(wdata));

    // 40 MHz clock in place of the programming oscillator; the logic counts edges only
    always #12.5 i_ref_clk = ~i_ref_clk;
    // Count result pulses and cut a hang short
    always @(posedge i_ref_clk) begin
        n_done += int'(o_write_done === 1'b1);
        n_ref += int'(o_write_refused === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk_data(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_data
    task automatic chk_flag(input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_flag
    // Write through the programmer, then compare pulses, lock bits and decodes
    task automatic wr(input logic [3:0] s, input logic [11:0] a, input logic [7:0] d, input int n);
        int   nd;
        int   nr;
        logic ok;
        logic [3:0] locks;
        nd = n_done;
        nr = n_ref;
        ok = n == 5 && (s inside {`OTPCM_SEL_PGM_SEC1, `OTPCM_SEL_PGM_SEC2, `OTPCM_SEL_PGM_SEC3} || sec_m == 3'h_0);
        i_external_access_select = seed[0];
        if (!sec_m[0])
            acc_m = seed[0]; // Access select is followed until bit 1 is set
        u_prog.wr(s, a, d, n);
        chk_flag(4'(ok), 4'(n_done - nd));
        chk_flag(4'(n == 5 && !ok), 4'(n_ref - nr));
        chk_flag(4'(acc_m), 4'(o_external_access_latched));
        if (ok) begin
            case (s)
                `OTPCM_SEL_PGM_CODE: mem[a] = d;
                `OTPCM_SEL_PGM_ENC:  enc[a[5:0]] = d;
                `OTPCM_SEL_PGM_SEC1: sec_m[0] = 1'b1;
                `OTPCM_SEL_PGM_SEC2: sec_m[1] = 1'b1;
                default:             sec_m[2] = 1'b1;
            endcase
        end
        chk_flag({1'b0, sec_m}, {1'b0, o_security_bits});
        locks = {o_ext_exec_block, o_verify_disable, o_program_disable, o_code_table_read_instruction_block};
        chk_flag({&sec_m, |sec_m[2:1], |sec_m, |sec_m}, locks);
    endtask : wr
    task automatic vrf(input logic [11:0] a);
        u_prog.rd(`OTPCM_SEL_VERIFY, a);
        chk_flag(4'(OTPCM_VERIFY), 4'(o_mode));
        chk_flag(4'(sec_m[2:1] == 2'b00), 4'(o_port0_oe));
        if (sec_m[2:1] == 2'b00) chk_data(~(mem[a] ^ enc[a[5:0]]), o_port0);
    endtask : vrf
    task automatic final_report();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // Blank the part, release reset, run the scenarios
    initial begin
        logic [11:0] aq [$];
        logic [3:0]  sc [3];
        sc = '{`OTPCM_SEL_PGM_SEC1, `OTPCM_SEL_PGM_SEC2, `OTPCM_SEL_PGM_SEC3};
        sec_m = 3'h_0;
        foreach (mem[i]) mem[i] = `OTPCM_BLANK_BYTE;
        foreach (enc[i]) enc[i] = `OTPCM_BLANK_BYTE;
        repeat (5) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        i_blank_init = 1'b0;
        for (int i = 0; i < 6; i++) begin
            aq.push_back(12'(xs()));
            wr(`OTPCM_SEL_PGM_CODE, aq[i], 8'(xs()), 5);
            vrf(aq[i]);
            vrf(~aq[i]);
        end
        $display("test code write finished");
        wr(`OTPCM_SEL_PGM_CODE, aq[0], 8'(xs()), 4);
        vrf(aq[0]);
        $display("test short pulse train finished");
        for (int i = 0; i < 32; i++) wr(`OTPCM_SEL_PGM_ENC, 12'(i), 8'(xs()), 5);
        foreach (aq[i]) vrf(aq[i]);
        $display("test encryption finished");
        for (int i = 0; i < 3; i++) begin
            u_prog.rd(`OTPCM_SEL_SIGNATURE, `OTPCM_SIG_ADDR_MAKER + 12'(i));
            chk_flag(4'(OTPCM_SIGNATURE), 4'(o_mode));
            chk_flag(4'(i < 2), 4'(o_port0_oe));
            if (i < 2) chk_data(i == 0 ? `OTPCM_ID_MAKER : `OTPCM_ID_PART, o_port0);
        end
        // Program store enable left high: no read mode may be entered
        store_en_n = 1'b1;
        u_prog.rd(`OTPCM_SEL_SIGNATURE, `OTPCM_SIG_ADDR_MAKER);
        chk_flag(4'(OTPCM_IDLE), 4'(o_mode));
        chk_flag(4'h_0, 4'(o_port0_oe));
        store_en_n = 1'b0;
        $display("test signature finished");
        foreach (sc[i]) begin
            wr(sc[i], aq[1], 8'(xs()), 5);
            wr(`OTPCM_SEL_PGM_CODE, aq[2], 8'(xs()), 5);
            wr(`OTPCM_SEL_PGM_ENC, 12'h_000, 8'(xs()), 5);
            vrf(aq[2]);
        end
        $display("test security finished");
        // Mid-run reset keeps the security bits; only a reset-pin fall reloads the access latch
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        i_external_access_select = 1'b1;
        @(negedge i_ref_clk);
        chk_flag({1'b0, sec_m}, {1'b0, o_security_bits});
        chk_flag(4'h_0, 4'(o_external_access_latched));
        chk_data(8'h_00, o_port0);
        rst_pin = 1'b0;
        @(negedge i_ref_clk);
        rst_pin = 1'b1;
        @(negedge i_ref_clk);
        chk_flag(4'h_1, 4'(o_external_access_latched));
        vrf(aq[2]);
        $display("test reset finished");
        final_report();
    end
endmodule : otpcm_core_tb
bind otpcm_core otpcm_checker u_chk (.*);
`default_nettype wire
